// file: rtl/adc_cfg_pkg.sv
// shared constants for the converter front-end configuration block
package adc_cfg_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ROUTE  = 8'h0C;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_CONVT  = 8'h14;
    // config field positions
    localparam int CFG_SEL_LSB   = 0;
    localparam int CFG_GAIN_LSB  = 4;
    localparam int CFG_BYP_BIT   = 7;
    localparam int CFG_CONT_BIT  = 8;
    localparam int CFG_TURBO_BIT = 9;
    // command bits
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT  = 1;
    // reset values
    localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RST  = 32'h0000_0000;
    localparam logic [31:0] CONVT_RST  = 32'h0000_0040;
    // input-select codes
    localparam logic [3:0] SEL_GND_FIRST = 4'h8;
    localparam logic [3:0] SEL_GND_LAST  = 4'hB;
    localparam logic [3:0] SEL_MON_REF   = 4'hC;
    localparam logic [3:0] SEL_MON_SUP   = 4'hD;
    // gain codes
    localparam logic [2:0] GAIN_X4 = 3'h2;
    // node codes for converter inputs and current source routing
    localparam logic [2:0] NODE_AIN0    = 3'h0;
    localparam logic [2:0] NODE_AIN1    = 3'h1;
    localparam logic [2:0] NODE_AIN2    = 3'h2;
    localparam logic [2:0] NODE_AIN3    = 3'h3;
    localparam logic [2:0] NODE_GND     = 3'h4;
    localparam logic [2:0] NODE_REF_P   = 3'h4;
    localparam logic [2:0] NODE_REF_N   = 3'h5;
    localparam logic [2:0] NODE_MON_SUP = 3'h6;
    localparam logic [2:0] NODE_MON_REF = 3'h7;
    localparam logic [2:0] NODE_OFF     = 3'h7;
    // start delays in converter clock periods
    localparam int START_DLY_NORMAL = 210;
    localparam int START_DLY_TURBO  = 114;
    // converter clock near 4.096 MHz derived from 200 MHz: period 48 cycles (48.828 truncated)
    localparam int CLK_HZ      = 200_000_000;
    localparam int CONV_CLK_HZ = 4_096_000;
    localparam int CONV_DIV    = CLK_HZ / CONV_CLK_HZ;
endpackage : adc_cfg_pkg

// file: rtl/input_select_decode.sv
// decode of input selection, bypass forcing and gain clamp
`timescale 1ns/100ps
`default_nettype none
module input_select_decode (
    input  wire logic [3:0] input_select_i,
    input  wire logic [2:0] gain_code_i,
    input  wire logic       amp_bypass_i,
    output logic [2:0]      pos_conv_input_o,
    output logic [2:0]      neg_conv_input_o,
    output logic            amp_powered_o,
    output logic [2:0]      gain_eff_o
);
    logic gnd_ref;

    assign gnd_ref = (input_select_i >= adc_cfg_pkg::SEL_GND_FIRST)
                  && (input_select_i <= adc_cfg_pkg::SEL_GND_LAST);

    always_comb begin
        pos_conv_input_o = adc_cfg_pkg::NODE_AIN0;
        neg_conv_input_o = adc_cfg_pkg::NODE_AIN1;
        case (input_select_i)
            4'h0: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN0;
                        neg_conv_input_o = adc_cfg_pkg::NODE_AIN1; end
            4'h1: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN0;
                        neg_conv_input_o = adc_cfg_pkg::NODE_AIN3; end
            4'h2: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN1;
                        neg_conv_input_o = adc_cfg_pkg::NODE_AIN3; end
            4'h3: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN2;
                        neg_conv_input_o = adc_cfg_pkg::NODE_AIN3; end
            4'h4: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN1;
                        neg_conv_input_o = adc_cfg_pkg::NODE_AIN0; end
            4'h5: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN3;
                        neg_conv_input_o = adc_cfg_pkg::NODE_AIN1; end
            4'h6: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN0;
                        neg_conv_input_o = adc_cfg_pkg::NODE_AIN2; end
            4'h7: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN3;
                        neg_conv_input_o = adc_cfg_pkg::NODE_AIN2; end
            4'h8, 4'h9, 4'hA, 4'hB: begin
                pos_conv_input_o = input_select_i[2:0] - 3'h0;
                neg_conv_input_o = adc_cfg_pkg::NODE_GND;
            end
            4'hC: begin pos_conv_input_o = adc_cfg_pkg::NODE_MON_REF;
                        neg_conv_input_o = adc_cfg_pkg::NODE_MON_REF; end
            4'hD: begin pos_conv_input_o = adc_cfg_pkg::NODE_MON_SUP;
                        neg_conv_input_o = adc_cfg_pkg::NODE_MON_SUP; end
            default: begin pos_conv_input_o = adc_cfg_pkg::NODE_AIN0;
                           neg_conv_input_o = adc_cfg_pkg::NODE_AIN0; end
        endcase
        if (gnd_ref) begin
            pos_conv_input_o = {1'b0, input_select_i[1:0]};
        end
    end

    // bypass allowed for gains up to 4, forced on ground-referenced selections
    assign amp_powered_o = !(gnd_ref
                          || (amp_bypass_i && gain_code_i <= adc_cfg_pkg::GAIN_X4));
    assign gain_eff_o = (gnd_ref && gain_code_i > adc_cfg_pkg::GAIN_X4)
                      ? adc_cfg_pkg::GAIN_X4 : gain_code_i;
endmodule : input_select_decode
`default_nettype wire

// file: rtl/conv_clock_div.sv
// divider producing the converter clock enable pulse
`timescale 1ns/100ps
`default_nettype none
module conv_clock_div #(
    parameter int DIV = 48
) (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    output logic      tick_o
);
    logic [15:0] cnt_r;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_r == 16'(DIV - 1)) begin
            cnt_r  <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : conv_clock_div
`default_nettype wire

// file: rtl/adc_input_gain_config.sv
// converter front-end configuration, decode and conversion sequencing
`timescale 1ns/100ps
`default_nettype none
module adc_input_gain_config #(
    parameter int CONV_DIV = adc_cfg_pkg::CONV_DIV
) (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_done_i,
    input  wire logic [15:0] conv_data_i,
    output logic [2:0]       pos_conv_input_o,
    output logic [2:0]       neg_conv_input_o,
    output logic             amp_powered_o,
    output logic [2:0]       gain_eff_o,
    output logic [2:0]       excite0_route_o,
    output logic [2:0]       excite1_route_o,
    output logic             conv_start_o,
    output logic             conv_active_o,
    output logic             low_power_o
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_SLEEP = 4'b1000
    } seq_e;

    seq_e        state_r;
    logic [31:0] config_r;
    logic [31:0] route_r;
    logic [31:0] convt_r;
    logic [15:0] result_r;
    logic        ready_r;
    logic [7:0]  dly_r;
    logic        tick;
    logic        wr_en;
    logic        rd_en;
    logic        start_cmd;
    logic        stop_cmd;
    logic [2:0]  pos_nxt;
    logic [2:0]  neg_nxt;
    logic        pwr_nxt;
    logic [2:0]  gain_nxt;

    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && penable && !pwrite;
    assign start_cmd = wr_en && paddr == adc_cfg_pkg::OFS_CMD
                    && pwdata[adc_cfg_pkg::CMD_START_BIT];
    assign stop_cmd  = wr_en && paddr == adc_cfg_pkg::OFS_CMD
                    && pwdata[adc_cfg_pkg::CMD_STOP_BIT];

    conv_clock_div #(
        .DIV (CONV_DIV)
    ) u_div (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .tick_o    (tick)
    );

    input_select_decode u_dec (
        .input_select_i   (config_r[adc_cfg_pkg::CFG_SEL_LSB +: 4]),
        .gain_code_i      (config_r[adc_cfg_pkg::CFG_GAIN_LSB +: 3]),
        .amp_bypass_i     (config_r[adc_cfg_pkg::CFG_BYP_BIT]),
        .pos_conv_input_o (pos_nxt),
        .neg_conv_input_o (neg_nxt),
        .amp_powered_o    (pwr_nxt),
        .gain_eff_o       (gain_nxt)
    );

    // apb slave: zero wait states, error on unmapped address
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    adc_cfg_pkg::OFS_CONFIG: prdata <= config_r;
                    adc_cfg_pkg::OFS_CMD:    prdata <= 32'h0000_0000;
                    adc_cfg_pkg::OFS_STATUS: prdata <= {28'h0000000, state_r == ST_SLEEP,
                                                        state_r == ST_CONV, 1'b0, ready_r};
                    adc_cfg_pkg::OFS_ROUTE:  prdata <= route_r;
                    adc_cfg_pkg::OFS_RESULT: prdata <= {16'h0000, result_r};
                    adc_cfg_pkg::OFS_CONVT:  prdata <= convt_r;
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // configuration registers
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            config_r <= adc_cfg_pkg::CONFIG_RST;
            route_r  <= adc_cfg_pkg::ROUTE_RST;
            convt_r  <= adc_cfg_pkg::CONVT_RST;
        end else if (wr_en && pready) begin
            case (paddr)
                adc_cfg_pkg::OFS_CONFIG: config_r <= {22'h000000, pwdata[9:0]};
                adc_cfg_pkg::OFS_ROUTE:  route_r  <= {26'h0000000, pwdata[5:0]};
                adc_cfg_pkg::OFS_CONVT:  convt_r  <= pwdata;
                default: ;
            endcase
        end
    end

    // decoded front-end outputs registered
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pos_conv_input_o <= adc_cfg_pkg::NODE_AIN0;
            neg_conv_input_o <= adc_cfg_pkg::NODE_AIN1;
            amp_powered_o    <= 1'b1;
            gain_eff_o       <= 3'h0;
            excite0_route_o  <= adc_cfg_pkg::NODE_OFF;
            excite1_route_o  <= adc_cfg_pkg::NODE_OFF;
        end else begin
            pos_conv_input_o <= pos_nxt;
            neg_conv_input_o <= neg_nxt;
            amp_powered_o    <= pwr_nxt;
            gain_eff_o       <= gain_nxt;
            excite0_route_o  <= route_r[2:0];
            excite1_route_o  <= route_r[5:3];
        end
    end

    // conversion sequencer
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r       <= ST_IDLE;
            dly_r         <= 8'h00;
            conv_start_o  <= 1'b0;
            conv_active_o <= 1'b0;
            low_power_o   <= 1'b1;
        end else begin
            conv_start_o <= 1'b0;
            case (state_r)
                ST_IDLE, ST_SLEEP: begin
                    if (start_cmd && pready) begin
                        state_r     <= ST_DELAY;
                        low_power_o <= 1'b0;
                        dly_r <= config_r[adc_cfg_pkg::CFG_TURBO_BIT]
                               ? 8'(adc_cfg_pkg::START_DLY_TURBO)
                               : 8'(adc_cfg_pkg::START_DLY_NORMAL);
                    end
                end
                ST_DELAY: begin
                    if (tick) begin
                        if (dly_r == 8'h01) begin
                            state_r       <= ST_CONV;
                            conv_start_o  <= 1'b1;
                            conv_active_o <= 1'b1;
                        end
                        dly_r <= dly_r - 8'h01;
                    end
                end
                ST_CONV: begin
                    if (conv_done_i) begin
                        if (config_r[adc_cfg_pkg::CFG_CONT_BIT] && !stop_cmd) begin
                            conv_start_o <= 1'b1;
                        end else begin
                            state_r       <= ST_SLEEP;
                            conv_active_o <= 1'b0;
                            low_power_o   <= 1'b1;
                        end
                    end else if (stop_cmd && pready) begin
                        state_r       <= ST_SLEEP;
                        conv_active_o <= 1'b0;
                        low_power_o   <= 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // result buffer and ready flag; new data wins over read clear
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_r <= 16'h0000;
            ready_r  <= 1'b0;
        end else if (conv_done_i && state_r == ST_CONV) begin
            result_r <= conv_data_i;
            ready_r  <= 1'b1;
        end else if (rd_en && pready && paddr == adc_cfg_pkg::OFS_RESULT) begin
            ready_r <= 1'b0;
        end
    end
endmodule : adc_input_gain_config
`default_nettype wire

// file: dv/adc_cfg_props.sv
// concurrent checks on the front-end configuration block ports
`timescale 1ns/100ps
`default_nettype none
module adc_cfg_props (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        conv_done_i,
    input wire logic [2:0]  pos_conv_input_o,
    input wire logic [2:0]  neg_conv_input_o,
    input wire logic        amp_powered_o,
    input wire logic [2:0]  gain_eff_o,
    input wire logic        conv_start_o,
    input wire logic        conv_active_o,
    input wire logic        low_power_o
);
    logic cont_r;
    logic cfg_wr;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    assign cfg_wr = psel && penable && pready && pwrite && (paddr == adc_cfg_pkg::OFS_CONFIG);
    // mirror of the continuous mode bit
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cont_r <= 1'b0;
        end else if (cfg_wr) begin
            cont_r <= pwdata[adc_cfg_pkg::CFG_CONT_BIT];
        end
    end
    a_pair_mon: assert property (pos_conv_input_o >= 3'h6 |-> neg_conv_input_o == pos_conv_input_o)
        else $error("monitor selection not paired");
    a_forced_bypass: assert property (neg_conv_input_o == adc_cfg_pkg::NODE_GND |-> !amp_powered_o)
        else $error("amplifier powered with ground-tied input");
    a_gain_clamp: assert property (!amp_powered_o |-> gain_eff_o <= adc_cfg_pkg::GAIN_X4)
        else $error("gain above four while bypassed");
    a_gnd_tie: assert property (cfg_wr && pwdata[3:0] inside {[4'h8:4'hB]} |-> ##2
        neg_conv_input_o == adc_cfg_pkg::NODE_GND && pos_conv_input_o == {1'b0, $past(pwdata[1:0], 2)})
        else $error("ground-tied selection decoded wrongly");
    a_cont_restart: assert property (conv_done_i && conv_active_o && cont_r |=> conv_start_o)
        else $error("continuous mode did not restart");
    a_single_sleep: assert property (conv_done_i && conv_active_o && !cont_r |-> ##[1:3] low_power_o)
        else $error("single conversion did not sleep");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o && conv_active_o)
        else $error("start pulse malformed");
    a_sleep_idle: assert property (low_power_o |-> !conv_active_o && !conv_start_o)
        else $error("converting while in low power");
endmodule : adc_cfg_props
bind adc_input_gain_config adc_cfg_props props_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .conv_done_i(conv_done_i), .pos_conv_input_o(pos_conv_input_o),
    .neg_conv_input_o(neg_conv_input_o), .amp_powered_o(amp_powered_o), .gain_eff_o(gain_eff_o),
    .conv_start_o(conv_start_o), .conv_active_o(conv_active_o), .low_power_o(low_power_o));
`default_nettype wire

// file: dv/conv_model.sv
// modulator and filter stand-in answering conversion starts
`timescale 1ns/100ps
`default_nettype none
module conv_model #(
    parameter int LAT = 30
) (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    input  wire logic start_i,
    output logic      done_o,
    output logic [15:0] data_o
);
    int          cnt_r;
    logic [15:0] val_r;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r  <= 0;
            done_o <= 1'b0;
            val_r  <= 16'h1234;
            data_o <= 16'hA5A5;
        end else begin
            done_o <= 1'b0;
            // result line not held after the done pulse
            if (done_o) begin
                data_o <= ~data_o;
                val_r  <= val_r + 16'h1111;
            end
            if (start_i) begin
                cnt_r <= LAT;
            end else if (cnt_r == 1) begin
                done_o <= 1'b1;
                data_o <= val_r;
                cnt_r  <= 0;
            end else if (cnt_r > 1) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule : conv_model
`default_nettype wire

// file: dv/adc_input_gain_config_test.sv
// self-checking bench for the front-end configuration block
`timescale 1ns/100ps
`default_nettype none
module adc_input_gain_config_test;
    localparam int LAT = 30;
    logic        clock_i, reset_n_i, psel, penable, pwrite, pready, pslverr, done, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] data;
    logic [2:0]  pos, neg, gain, ex0, ex1;
    logic        amp, cstart, cact, lowp;
    int          miscompares, checks_done, n;
    logic [2:0]  pos_tab [16] = '{0, 0, 1, 2, 1, 3, 0, 3, 0, 1, 2, 3, 7, 6, 0, 0};
    logic [2:0]  neg_tab [16] = '{1, 3, 3, 3, 0, 1, 2, 2, 4, 4, 4, 4, 7, 6, 0, 0};

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    adc_input_gain_config #(.CONV_DIV(2)) dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done_i(done),
        .conv_data_i(data), .pos_conv_input_o(pos), .neg_conv_input_o(neg),
        .amp_powered_o(amp), .gain_eff_o(gain), .excite0_route_o(ex0), .excite1_route_o(ex1),
        .conv_start_o(cstart), .conv_active_o(cact), .low_power_o(lowp));
    conv_model #(.LAT(LAT)) model_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .start_i(cstart), .done_o(done), .data_o(data));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clock_i); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin miscompares++; finish_test(); end
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wait_start;
        n = 0;
        do begin @(posedge clock_i); n++; end while (cstart !== 1'b1 && n < 2000);
        if (n >= 2000) begin miscompares++; finish_test(); end
    endtask : wait_start
    task automatic cfg_settle(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge clock_i);
    endtask : cfg_settle

    task automatic test_reset;
        chk(lowp, 1'b1);
        chk({ex0, ex1}, 6'h3F);
        apb(1'b0, adc_cfg_pkg::OFS_CONFIG, 32'h0); chk(q, adc_cfg_pkg::CONFIG_RST);
        apb(1'b0, adc_cfg_pkg::OFS_ROUTE, 32'h0); chk(q, adc_cfg_pkg::ROUTE_RST);
    endtask : test_reset
    task automatic test_select;
        for (int s = 0; s < 16; s++) begin
            cfg_settle(adc_cfg_pkg::OFS_CONFIG, 32'h70 | 32'(s));
            chk(pos, pos_tab[s]);
            chk(neg, neg_tab[s]);
            chk(amp, s < 8 || s > 11);
            chk(gain, (s >= 8 && s <= 11) ? 3'h2 : 3'h7);
        end
        cfg_settle(adc_cfg_pkg::OFS_CONFIG, 32'h88);
        chk(amp, 1'b0);
    endtask : test_select
    task automatic test_gain;
        for (int g = 0; g < 8; g++) begin
            cfg_settle(adc_cfg_pkg::OFS_CONFIG, (32'(g) << 4) | 32'h80);
            chk(gain, g[2:0]);
            chk(amp, g > 2);
        end
    endtask : test_gain
    task automatic test_route;
        for (int k = 0; k < 6; k++) begin
            cfg_settle(adc_cfg_pkg::OFS_ROUTE, 32'(k) | (32'(5 - k) << 3));
            chk({ex0, ex1}, {k[2:0], 3'(5 - k)});
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(e, 1'b1);
        chk(q, 32'h0);
        apb(1'b0, adc_cfg_pkg::OFS_CMD, 32'h0); chk(q, 32'h0);
    endtask : test_route
    task automatic test_single;
        int cnt;
        apb(1'b1, adc_cfg_pkg::OFS_CONFIG, 32'h0);
        apb(1'b1, adc_cfg_pkg::OFS_CMD, 32'h1);
        wait_start();
        chk(n >= 418 && n <= 426, 1'b1);
        repeat (LAT + 5) @(posedge clock_i);
        chk({lowp, cact}, 2'b10);
        apb(1'b0, adc_cfg_pkg::OFS_STATUS, 32'h0); chk(q[0], 1'b1);
        apb(1'b0, adc_cfg_pkg::OFS_RESULT, 32'h0); chk(q, 32'h1234);
        cnt = 0;
        repeat (500) begin @(posedge clock_i); cnt += cstart; end
        chk(cnt, 0);
    endtask : test_single
    task automatic test_cont;
        apb(1'b1, adc_cfg_pkg::OFS_CONFIG, 32'h300);
        apb(1'b1, adc_cfg_pkg::OFS_CMD, 32'h1);
        wait_start();
        chk(n >= 224 && n <= 234, 1'b1);
        wait_start();
        chk(n >= LAT && n <= LAT + 3, 1'b1);
        wait_start();
        chk(n >= LAT && n <= LAT + 3, 1'b1);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk({lowp, cact}, 2'b10);
        reset_n_i <= 1'b1;
    endtask : test_cont
    task automatic test_stop;
        int cnt;
        apb(1'b1, adc_cfg_pkg::OFS_CONFIG, 32'h100);
        apb(1'b1, adc_cfg_pkg::OFS_CMD, 32'h1);
        wait_start();
        wait_start();
        chk(n >= LAT && n <= LAT + 3, 1'b1);
        // stop lands mid-conversion, before the model answers
        apb(1'b1, adc_cfg_pkg::OFS_CMD, 32'h2);
        repeat (2) @(posedge clock_i);
        chk({lowp, cact}, 2'h2);
        apb(1'b0, adc_cfg_pkg::OFS_STATUS, 32'h0);
        chk(q[3:2], 2'h2);
        cnt = 0;
        repeat (100) begin @(posedge clock_i); cnt += cstart; end
        chk(cnt, 0);
    endtask : test_stop

    initial begin
        reset_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; miscompares = 0; checks_done = 0;
        repeat (10) @(posedge clock_i);
        reset_n_i <= 1'b1;
        test_reset();
        test_select();
        test_gain();
        test_route();
        test_single();
        test_cont();
        test_single();
        test_stop();
        finish_test();
    end
endmodule : adc_input_gain_config_test
`default_nettype wire
